// File: core/bsp_pkg.sv
// constants of the buffered serial port pin logic
// assumes one core clock domain plus one clock per link section
// Summary of operation
// - receiver shifts bits in on the receive bit clock
// - receive frame sync pulse starts each received word
// - third port: one shared frame sync serves transmit and receive
// - transmitter shifts bits out on the transmit bit clock
// - transmit bit clock pin is an input after reset
// - transmit frame sync pulse starts each transmitted word
// - transmit frame sync pin is an input after reset
// - transmit data floats when idle, in reset, or float control low
// - transmit bit clock pin floats while float control is low
// - transmit frame sync pin floats while float control is low
// - device reset reinitialises both sections to reset configuration
package bsp_pkg;
  // ==========================================================
  // sizes
  localparam int WORD_BITS = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int SHARED_FRAME_SYNC = 0;
  // ==========================================================
  // reset values
  localparam logic OE_N_RST = 1'b1;
  localparam logic PIN_OUT_RST = 1'b0;
  localparam logic TOGGLE_RST = 1'b0;
  // ==========================================================
  // section states, gray along idle -> shift
  typedef enum logic [0:0] {
    BSP_IDLE = 1'b0,
    BSP_SHIFT = 1'b1
  } bsp_state_t;
endpackage

// File: core/bsp_sync.sv
// two-flop synchroniser for levels and toggles
// assumes the input is stable long enough to be sampled
`timescale 1ns/1ns
`default_nettype none
module bsp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;
  // ==========================================================
  // first stage feeds the second only
  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_o <= meta_reg;
  end
endmodule
`default_nettype wire

// File: core/bsp_fifo.sv
// small synchronous fifo, registered flags
// assumes writer and reader share clk_i
`timescale 1ns/1ns
`default_nettype none
module bsp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;
  // ==========================================================
  // pointers and flags
  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      in_ready_o <= (cnt_next != FULL);
      out_valid_o <= (cnt_next != '0);
    end
  end
  // ==========================================================
  // storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end
  assign out_data_o = mem[rd_reg];
endmodule
`default_nettype wire

// File: core/bsp_port.sv
// one buffered serial port: receive and transmit sections at the pins
// assumes bit clocks keep running while SYS_RST_I is high
`timescale 1ns/1ns
`default_nettype none
module bsp_port #(
  parameter int WORD_BITS = bsp_pkg::WORD_BITS,
  parameter int FIFO_DEPTH = bsp_pkg::FIFO_DEPTH,
  parameter int SHARED_FRAME_SYNC = bsp_pkg::SHARED_FRAME_SYNC
) (
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic FLOAT_N_I,
  input wire logic TX_FS_DRIVE_I,
  input wire logic [WORD_BITS-1:0] TX_WORD_I,
  input wire logic TX_VALID_I,
  output logic TX_READY_O,
  output logic [WORD_BITS-1:0] RX_WORD_O,
  output logic RX_VALID_O,
  input wire logic RX_READY_I,
  output logic RX_OVERRUN_O,
  input wire logic RECEIVE_BIT_CLOCK_I,
  output logic RECEIVE_BIT_CLOCK_O,
  output logic RECEIVE_BIT_CLOCK_OE_N_O,
  input wire logic RECEIVE_SERIAL_DATA_I,
  input wire logic RECEIVE_FRAME_SYNC_I,
  output logic RECEIVE_FRAME_SYNC_O,
  output logic RECEIVE_FRAME_SYNC_OE_N_O,
  input wire logic TRANSMIT_BIT_CLOCK_I,
  output logic TRANSMIT_BIT_CLOCK_O,
  output logic TRANSMIT_BIT_CLOCK_OE_N_O,
  output logic TRANSMIT_SERIAL_DATA_O,
  output logic TRANSMIT_SERIAL_DATA_OE_N_O,
  input wire logic TRANSMIT_FRAME_SYNC_I,
  output logic TRANSMIT_FRAME_SYNC_O,
  output logic TRANSMIT_FRAME_SYNC_OE_N_O
);
  localparam int CW = (WORD_BITS > 1) ? $clog2(WORD_BITS) : 1;
  localparam logic [CW-1:0] LAST_BIT = (CW)'(WORD_BITS - 1);
  localparam logic SHARED = (SHARED_FRAME_SYNC != 0);

  // ==========================================================
  // core domain signals
  logic fifo_valid;
  logic [WORD_BITS-1:0] fifo_word;
  logic fifo_pop;
  logic tx_req_reg, tx_req_next;
  logic [WORD_BITS-1:0] tx_hold_reg, tx_hold_next;
  logic tx_ack_core;
  logic rx_tog_core, rx_tog_seen_reg, rx_tog_seen_next;
  logic rx_new;
  logic [WORD_BITS-1:0] rx_word_out_next;
  logic rx_valid_next, rx_overrun_next;
  // ==========================================================
  // receive domain signals
  logic rx_rst;
  bsp_pkg::bsp_state_t rx_state_reg, rx_state_next;
  logic [CW-1:0] rx_cnt_reg, rx_cnt_next;
  logic [WORD_BITS-1:0] rx_sh_reg, rx_sh_next;
  logic [WORD_BITS-1:0] rx_word_reg, rx_word_next;
  logic rx_tog_reg, rx_tog_next;
  // ==========================================================
  // transmit domain signals
  logic tx_rst, tx_float_n, tx_drive, tx_req_link;
  bsp_pkg::bsp_state_t tx_state_reg, tx_state_next;
  logic [CW-1:0] tx_cnt_reg, tx_cnt_next;
  logic [WORD_BITS-1:0] tx_sh_reg, tx_sh_next;
  logic tx_ack_reg, tx_ack_next;
  logic tx_fs_out_reg, tx_fs_out_next;
  logic tx_dat_oe_n_reg, tx_dat_oe_n_next;
  logic tx_fs_oe_n_reg, tx_fs_oe_n_next;
  logic tx_fs, tx_pending, tx_start, tx_last;
  logic tx_drive_en;
  // ==========================================================
  // pin direction signals, core domain
  logic rx_clk_out_next;
  logic rx_clk_oe_n_next;
  logic rx_fs_out_next;
  logic rx_fs_oe_n_next;
  logic tx_clk_out_next;
  logic tx_clk_oe_n_next;

  // ==========================================================
  // transmit word buffer; full fifo stalls the user side
  bsp_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(TX_VALID_I),
    .in_data_i(TX_WORD_I),
    .in_ready_o(TX_READY_O),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_word),
    .out_ready_i(fifo_pop)
  );

  // ==========================================================
  // crossings
  bsp_sync #(.WIDTH(1)) u_ack_sync (
    .clk_i(CORE_CLK_I),
    .d_i(tx_ack_reg),
    .q_o(tx_ack_core)
  );
  bsp_sync #(.WIDTH(1)) u_rxtog_sync (
    .clk_i(CORE_CLK_I),
    .d_i(rx_tog_reg),
    .q_o(rx_tog_core)
  );
  bsp_sync #(.WIDTH(1)) u_rx_rst_sync (
    .clk_i(RECEIVE_BIT_CLOCK_I),
    .d_i(SYS_RST_I),
    .q_o(rx_rst)
  );
  bsp_sync #(.WIDTH(4)) u_tx_sync (
    .clk_i(TRANSMIT_BIT_CLOCK_I),
    .d_i({SYS_RST_I, FLOAT_N_I, TX_FS_DRIVE_I, tx_req_reg}),
    .q_o({tx_rst, tx_float_n, tx_drive, tx_req_link})
  );

  // ==========================================================
  // core side: hand words to the transmitter, collect received words
  always_comb begin
    // hold word is stable while request and ack differ
    fifo_pop = fifo_valid && (tx_req_reg == tx_ack_core);
    tx_req_next = tx_req_reg ^ fifo_pop;
    tx_hold_next = fifo_pop ? fifo_word : tx_hold_reg;
    rx_new = rx_tog_core ^ rx_tog_seen_reg;
    rx_tog_seen_next = rx_tog_core;
    rx_word_out_next = RX_WORD_O;
    rx_valid_next = RX_VALID_O && !RX_READY_I;
    rx_overrun_next = 1'b0;
    if (rx_new) begin
      // word crossed whole; it stays put for a full word time
      if (RX_VALID_O && !RX_READY_I) begin
        rx_overrun_next = 1'b1;
      end else begin
        rx_word_out_next = rx_word_reg;
        rx_valid_next = 1'b1;
      end
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      tx_req_reg <= bsp_pkg::TOGGLE_RST;
      tx_hold_reg <= '0;
      rx_tog_seen_reg <= bsp_pkg::TOGGLE_RST;
      RX_WORD_O <= '0;
      RX_VALID_O <= 1'b0;
      RX_OVERRUN_O <= 1'b0;
    end else begin
      tx_req_reg <= tx_req_next;
      tx_hold_reg <= tx_hold_next;
      rx_tog_seen_reg <= rx_tog_seen_next;
      RX_WORD_O <= rx_word_out_next;
      RX_VALID_O <= rx_valid_next;
      RX_OVERRUN_O <= rx_overrun_next;
    end
  end

  // ==========================================================
  // pins the device never drives: bit clocks and receive sync
  // no clock master mode here; such a mode would change only these
  always_comb begin
    rx_clk_out_next = bsp_pkg::PIN_OUT_RST;
    rx_clk_oe_n_next = bsp_pkg::OE_N_RST;
    rx_fs_out_next = bsp_pkg::PIN_OUT_RST;
    rx_fs_oe_n_next = bsp_pkg::OE_N_RST;
    tx_clk_out_next = bsp_pkg::PIN_OUT_RST;
    tx_clk_oe_n_next = bsp_pkg::OE_N_RST;
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      RECEIVE_BIT_CLOCK_O <= bsp_pkg::PIN_OUT_RST;
      RECEIVE_BIT_CLOCK_OE_N_O <= bsp_pkg::OE_N_RST;
      RECEIVE_FRAME_SYNC_O <= bsp_pkg::PIN_OUT_RST;
      RECEIVE_FRAME_SYNC_OE_N_O <= bsp_pkg::OE_N_RST;
      TRANSMIT_BIT_CLOCK_O <= bsp_pkg::PIN_OUT_RST;
      TRANSMIT_BIT_CLOCK_OE_N_O <= bsp_pkg::OE_N_RST;
    end else begin
      RECEIVE_BIT_CLOCK_O <= rx_clk_out_next;
      RECEIVE_BIT_CLOCK_OE_N_O <= rx_clk_oe_n_next;
      RECEIVE_FRAME_SYNC_O <= rx_fs_out_next;
      RECEIVE_FRAME_SYNC_OE_N_O <= rx_fs_oe_n_next;
      TRANSMIT_BIT_CLOCK_O <= tx_clk_out_next;
      TRANSMIT_BIT_CLOCK_OE_N_O <= tx_clk_oe_n_next;
    end
  end

  // ==========================================================
  // receive section, on its own bit clock
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_sh_next = rx_sh_reg;
    rx_word_next = rx_word_reg;
    rx_tog_next = rx_tog_reg;
    unique case (rx_state_reg)
      bsp_pkg::BSP_IDLE: begin
        // first bit comes on the edge after the sync
        if (RECEIVE_FRAME_SYNC_I) begin
          rx_state_next = bsp_pkg::BSP_SHIFT;
          rx_cnt_next = '0;
        end
      end
      bsp_pkg::BSP_SHIFT: begin
        // syncs inside a word are ignored
        rx_sh_next = {rx_sh_reg[WORD_BITS-2:0], RECEIVE_SERIAL_DATA_I};
        rx_cnt_next = rx_cnt_reg + 1'b1;
        if (rx_cnt_reg == LAST_BIT) begin
          rx_word_next = rx_sh_next;
          rx_tog_next = ~rx_tog_reg;
          rx_cnt_next = '0;
          rx_state_next = RECEIVE_FRAME_SYNC_I ? bsp_pkg::BSP_SHIFT
                                               : bsp_pkg::BSP_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge RECEIVE_BIT_CLOCK_I) begin
    if (rx_rst) begin
      rx_state_reg <= bsp_pkg::BSP_IDLE;
      rx_cnt_reg <= '0;
      rx_sh_reg <= '0;
      rx_word_reg <= '0;
      rx_tog_reg <= bsp_pkg::TOGGLE_RST;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_sh_reg <= rx_sh_next;
      rx_word_reg <= rx_word_next;
      rx_tog_reg <= rx_tog_next;
    end
  end

  // ==========================================================
  // transmit section, on its own bit clock
  always_comb begin
    tx_drive_en = tx_drive && !SHARED;
    tx_pending = tx_req_link ^ tx_ack_reg;
    // shared sync is sampled raw: both bit clocks must be one clock
    if (SHARED) begin
      tx_fs = RECEIVE_FRAME_SYNC_I;
    end else if (tx_drive) begin
      tx_fs = tx_fs_out_reg;
    end else begin
      tx_fs = TRANSMIT_FRAME_SYNC_I;
    end
    tx_last = (tx_state_reg == bsp_pkg::BSP_SHIFT) && (tx_cnt_reg == LAST_BIT);
    tx_start = tx_fs && ((tx_state_reg == bsp_pkg::BSP_IDLE) || tx_last);
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_sh_next = tx_sh_reg;
    tx_ack_next = tx_ack_reg;
    // self-made sync: one bit wide, only between words
    tx_fs_out_next = tx_drive_en && tx_pending && !tx_fs_out_reg
                     && (tx_state_reg == bsp_pkg::BSP_IDLE);
    if (tx_start && tx_pending) begin
      tx_state_next = bsp_pkg::BSP_SHIFT;
      tx_cnt_next = '0;
      tx_sh_next = tx_hold_reg;
      tx_ack_next = ~tx_ack_reg;
    end else if (tx_last) begin
      // sync without a word leaves the line floating
      tx_state_next = bsp_pkg::BSP_IDLE;
      tx_cnt_next = '0;
    end else if (tx_state_reg == bsp_pkg::BSP_SHIFT) begin
      tx_sh_next = {tx_sh_reg[WORD_BITS-2:0], 1'b0};
      tx_cnt_next = tx_cnt_reg + 1'b1;
    end
    tx_dat_oe_n_next = !(tx_float_n
                         && (tx_state_next == bsp_pkg::BSP_SHIFT));
    tx_fs_oe_n_next = !(tx_float_n && tx_drive_en);
  end
  always_ff @(posedge TRANSMIT_BIT_CLOCK_I) begin
    if (tx_rst) begin
      tx_state_reg <= bsp_pkg::BSP_IDLE;
      tx_cnt_reg <= '0;
      tx_sh_reg <= '0;
      tx_ack_reg <= bsp_pkg::TOGGLE_RST;
      tx_fs_out_reg <= bsp_pkg::PIN_OUT_RST;
      tx_dat_oe_n_reg <= bsp_pkg::OE_N_RST;
      tx_fs_oe_n_reg <= bsp_pkg::OE_N_RST;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_sh_reg <= tx_sh_next;
      tx_ack_reg <= tx_ack_next;
      tx_fs_out_reg <= tx_fs_out_next;
      tx_dat_oe_n_reg <= tx_dat_oe_n_next;
      tx_fs_oe_n_reg <= tx_fs_oe_n_next;
    end
  end
  // msb first, straight from the shifter
  assign TRANSMIT_SERIAL_DATA_O = tx_sh_reg[WORD_BITS-1];
  assign TRANSMIT_SERIAL_DATA_OE_N_O = tx_dat_oe_n_reg;
  assign TRANSMIT_FRAME_SYNC_O = tx_fs_out_reg;
  assign TRANSMIT_FRAME_SYNC_OE_N_O = tx_fs_oe_n_reg;
endmodule
`default_nettype wire

// File: dv/bsp_port_properties.sv
// checker for the serial port pins, bound to bsp_port
// assumes bit clocks run during reset, as the port requires
`timescale 1ns/1ns
`default_nettype none
module bsp_port_properties #(
  parameter int WORD_BITS = 16
) (
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic FLOAT_N_I,
  input wire logic RX_VALID_O,
  input wire logic RX_READY_I,
  input wire logic [WORD_BITS-1:0] RX_WORD_O,
  input wire logic RX_OVERRUN_O,
  input wire logic TRANSMIT_BIT_CLOCK_I,
  input wire logic TRANSMIT_FRAME_SYNC_I,
  input wire logic RECEIVE_BIT_CLOCK_OE_N_O,
  input wire logic RECEIVE_FRAME_SYNC_OE_N_O,
  input wire logic TRANSMIT_BIT_CLOCK_OE_N_O,
  input wire logic TRANSMIT_SERIAL_DATA_OE_N_O,
  input wire logic TRANSMIT_FRAME_SYNC_OE_N_O
);
  // ========================================================
  // run length of driven data, in transmit clocks
  logic [7:0] run_reg;
  logic [7:0] run_next;
  always_comb begin
    run_next = TRANSMIT_SERIAL_DATA_OE_N_O ? 8'h00 : run_reg + 8'h01;
  end
  always_ff @(posedge TRANSMIT_BIT_CLOCK_I) begin
    run_reg <= run_next;
  end
  // ========================================================
  // properties
  a_rx_pins_input: assert property (@(posedge CORE_CLK_I)
    disable iff (SYS_RST_I)
    RECEIVE_BIT_CLOCK_OE_N_O && RECEIVE_FRAME_SYNC_OE_N_O)
    else $error("receive clock or sync pin driven");
  a_tx_clk_input: assert property (@(posedge CORE_CLK_I)
    disable iff (SYS_RST_I) TRANSMIT_BIT_CLOCK_OE_N_O)
    else $error("transmit clock pin driven");
  // no disable: this one is about reset itself
  a_rst_floats: assert property (@(posedge TRANSMIT_BIT_CLOCK_I)
    SYS_RST_I [*4] |->
    TRANSMIT_SERIAL_DATA_OE_N_O && TRANSMIT_FRAME_SYNC_OE_N_O)
    else $error("transmit pins driven in reset");
  a_rst_core: assert property (@(posedge CORE_CLK_I)
    SYS_RST_I |=> !RX_VALID_O && !RX_OVERRUN_O)
    else $error("receive outputs active in reset");
  a_float_data: assert property (@(posedge TRANSMIT_BIT_CLOCK_I)
    disable iff (SYS_RST_I) !FLOAT_N_I [*4] |-> TRANSMIT_SERIAL_DATA_OE_N_O)
    else $error("data driven while floated");
  a_float_sync: assert property (@(posedge TRANSMIT_BIT_CLOCK_I)
    disable iff (SYS_RST_I) !FLOAT_N_I [*4] |-> TRANSMIT_FRAME_SYNC_OE_N_O)
    else $error("sync driven while floated");
  a_start_sync: assert property (@(posedge TRANSMIT_BIT_CLOCK_I)
    disable iff (SYS_RST_I || !FLOAT_N_I)
    $fell(TRANSMIT_SERIAL_DATA_OE_N_O) |-> $past(TRANSMIT_FRAME_SYNC_I))
    else $error("transmission began without sync");
  a_word_len: assert property (@(posedge TRANSMIT_BIT_CLOCK_I)
    disable iff (SYS_RST_I || !FLOAT_N_I)
    $rose(TRANSMIT_SERIAL_DATA_OE_N_O) |->
    run_reg != 8'h00 && run_reg % WORD_BITS == 0)
    else $error("transmit run not whole words");
  a_rx_hold: assert property (@(posedge CORE_CLK_I)
    disable iff (SYS_RST_I)
    RX_VALID_O && !RX_READY_I |=> RX_VALID_O && $stable(RX_WORD_O))
    else $error("received word lost before taken");
endmodule
bind bsp_port bsp_port_properties #(.WORD_BITS(WORD_BITS))
  i_bsp_port_properties (.*);
`default_nettype wire

// File: dv/bsp_peer.sv
// serial peer: feeds the receive link, samples the transmit link
// assumes both bit clocks come from the bench and run free
`timescale 1ns/1ns
`default_nettype none
module bsp_peer #(
  parameter int W = 16
) (
  input wire logic rclk_i,
  input wire logic tclk_i,
  input wire logic tdata_i,
  input wire logic toe_n_i,
  output logic rdata_o,
  output logic rfs_o,
  output logic tfs_o
);
  // ========================================================
  // link tasks, launched on falling edges
  initial begin
    rdata_o = 1'b0;
    rfs_o = 1'b0;
    tfs_o = 1'b0;
  end
  task automatic rx_word(input logic [W-1:0] w);
    @(negedge rclk_i);
    rfs_o = 1'b1;
    @(negedge rclk_i);
    rfs_o = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      rdata_o = w[i];
      @(negedge rclk_i);
    end
    // no pull on the line: show the inverse, not a stale bit
    rdata_o = ~w[0];
  endtask
  task automatic tx_sync;
    @(negedge tclk_i);
    tfs_o = 1'b1;
    @(negedge tclk_i);
    tfs_o = 1'b0;
  endtask
  task automatic tx_take(output logic [W-1:0] w, output logic ok);
    int t;
    t = 0;
    ok = 1'b1;
    w = '0;
    while (toe_n_i !== 1'b0 && t < 64) begin
      @(negedge tclk_i);
      t++;
    end
    for (int i = W - 1; i >= 0; i--) begin
      w[i] = tdata_i;
      if (toe_n_i !== 1'b0) ok = 1'b0;
      @(negedge tclk_i);
    end
  endtask
endmodule
`default_nettype wire

// File: dv/bsp_port_test.sv
// self-checking bench of bsp_port with the serial peer
// assumes the checker is bound to bsp_port
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("wrong value %s expected %h seen %h", n, e, g); \
  end \
end
module bsp_port_test;
  localparam int W = bsp_pkg::WORD_BITS;
  logic clk = 1'b0;
  logic rclk = 1'b0;
  logic tclk = 1'b0;
  logic rst = 1'b1;
  logic float_n = 1'b1;
  logic fs_drive = 1'b0;
  logic [W-1:0] tx_word = '0;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic tx_ready, rx_valid, ovr, rdata, rfs, pfs, tfs_o, tfs_oe_n;
  logic tdata, tdoe_n, tcoe_n;
  logic [W-1:0] rx_word;
  int failures = 0;
  int check_count = 0;
  int ovr_n = 0;
  // sync pin level: device when it drives, peer otherwise
  wire logic tfs = tfs_oe_n ? pfs : tfs_o;
  // ========================================================
  // clocks, design, peer
  always #20 clk = ~clk;
  initial #7 forever #32 rclk = ~rclk;
  initial #19 forever #32 tclk = ~tclk;
  always @(negedge clk) if (ovr === 1'b1) ovr_n++;
  bsp_port i_bsp_port (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .FLOAT_N_I(float_n), .TX_FS_DRIVE_I(fs_drive), .TX_WORD_I(tx_word),
    .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .RX_WORD_O(rx_word),
    .RX_VALID_O(rx_valid), .RX_READY_I(rx_ready), .RX_OVERRUN_O(ovr),
    .RECEIVE_BIT_CLOCK_I(rclk), .RECEIVE_BIT_CLOCK_O(),
    .RECEIVE_BIT_CLOCK_OE_N_O(), .RECEIVE_SERIAL_DATA_I(rdata),
    .RECEIVE_FRAME_SYNC_I(rfs), .RECEIVE_FRAME_SYNC_O(),
    .RECEIVE_FRAME_SYNC_OE_N_O(), .TRANSMIT_BIT_CLOCK_I(tclk),
    .TRANSMIT_BIT_CLOCK_O(), .TRANSMIT_BIT_CLOCK_OE_N_O(tcoe_n),
    .TRANSMIT_SERIAL_DATA_O(tdata), .TRANSMIT_SERIAL_DATA_OE_N_O(tdoe_n),
    .TRANSMIT_FRAME_SYNC_I(tfs), .TRANSMIT_FRAME_SYNC_O(tfs_o),
    .TRANSMIT_FRAME_SYNC_OE_N_O(tfs_oe_n));
  bsp_peer #(.W(W)) i_bsp_peer (.rclk_i(rclk), .tclk_i(tclk),
    .tdata_i(tdata), .toe_n_i(tdoe_n), .rdata_o(rdata), .rfs_o(rfs),
    .tfs_o(pfs));
  // ========================================================
  // shared tasks
  task automatic push(input logic [W-1:0] w);
    int t;
    t = 0;
    @(negedge clk);
    tx_word = w;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && t < 100) begin
      @(negedge clk);
      t++;
    end
    `CHK("tx ready", 1'b1, tx_ready)
    @(negedge clk);
    tx_valid = 1'b0;
    repeat (6) @(negedge tclk);
  endtask
  task automatic rx_get(input logic [W-1:0] w);
    int t;
    t = 0;
    @(negedge clk);
    while (rx_valid !== 1'b1 && t < 100) begin
      @(negedge clk);
      t++;
    end
    `CHK("rx valid", 1'b1, rx_valid)
    `CHK("rx word", w, rx_word)
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask
  task automatic tx_check(input logic drive, input logic [W-1:0] w);
    logic [W-1:0] got;
    logic ok;
    if (drive) i_bsp_peer.tx_sync();
    i_bsp_peer.tx_take(got, ok);
    `CHK("tx driven", 1'b1, ok)
    `CHK("tx word", w, got)
  endtask
  task automatic chk_rst;
    `CHK("ready in reset", 1'b0, tx_ready)
    `CHK("clock oe_n", 1'b1, tcoe_n)
    `CHK("sync oe_n", 1'b1, tfs_oe_n)
    `CHK("data oe_n", 1'b1, tdoe_n)
  endtask
  // ========================================================
  // scenarios
  task automatic t_rx;
    int o;
    i_bsp_peer.rx_word(16'ha5c3);
    rx_get(16'ha5c3);
    o = ovr_n;
    i_bsp_peer.rx_word(16'h0ff1);
    i_bsp_peer.rx_word(16'h7e18);
    repeat (8) @(negedge clk);
    `CHK("overrun", o + 1, ovr_n)
    rx_get(16'h0ff1);
  endtask
  task automatic t_tx;
    i_bsp_peer.tx_sync();
    repeat (4) @(negedge tclk);
    `CHK("idle oe_n", 1'b1, tdoe_n)
    push(16'h8001);
    tx_check(1'b1, 16'h8001);
    push(16'h6996);
    fork
      i_bsp_peer.rx_word(16'h3c5a);
      tx_check(1'b1, 16'h6996);
    join
    rx_get(16'h3c5a);
    fs_drive = 1'b1;
    // self-made sync starts the word while push still waits
    fork
      push(16'hb44d);
      tx_check(1'b0, 16'hb44d);
    join
    @(negedge clk);
    fs_drive = 1'b0;
  endtask
  // far side stalls while the buffer fills, then drains it
  task automatic t_fill;
    int n;
    n = 0;
    repeat (12) begin
      @(negedge clk);
      tx_word = W'(32'hc000 + n);
      tx_valid = 1'b1;
      if (tx_ready === 1'b1) n++;
    end
    @(negedge clk);
    tx_valid = 1'b0;
    `CHK("fill count", 5, n)
    for (int i = 0; i < n; i++) begin
      repeat (6) @(negedge tclk);
      tx_check(1'b1, W'(32'hc000 + i));
    end
    `CHK("ready after drain", 1'b1, tx_ready)
  endtask
  task automatic t_float;
    @(negedge clk);
    float_n = 1'b0;
    fs_drive = 1'b1;
    push(16'h55aa);
    `CHK("float data", 1'b1, tdoe_n)
    `CHK("float sync", 1'b1, tfs_oe_n)
    `CHK("float clock", 1'b1, tcoe_n)
    // a word left pending must not survive reset
    @(negedge clk);
    fs_drive = 1'b0;
    push(16'h0f0f);
    @(negedge clk);
    rst = 1'b1;
    repeat (8) @(negedge clk);
    chk_rst;
    rst = 1'b0;
    fs_drive = 1'b0;
    float_n = 1'b1;
    repeat (4) @(negedge tclk);
    i_bsp_peer.tx_sync();
    repeat (4) @(negedge tclk);
    `CHK("word cleared", 1'b1, tdoe_n)
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    chk_rst;
    rst = 1'b0;
    repeat (8) @(negedge clk);
    t_rx;
    t_tx;
    t_fill;
    t_float;
    end_of_test;
  end
  // whole run is near 20 us; ten times that means a hang
  initial begin
    #200000;
    failures++;
    end_of_test;
  end
endmodule
`default_nettype wire
